// ### src/pcpc_defs.svh
`ifndef PCPC_DEFS_SVH
`define PCPC_DEFS_SVH

// ==========================================
// Register addresses
`define PCPC_IDX_POWER        8'h02
`define PCPC_IDX_INTGEN       8'h03
`define PCPC_MEM_POWER        12'h802
`define PCPC_MEM_INTGEN       12'h803

// ==========================================
// Reset values
`define PCPC_POWER_RST        8'h00
`define PCPC_INTGEN_RST       8'h00

// ==========================================
// Power-control fields
`define PCPC_POWER_WMASK      8'h9B
`define PCPC_COE_BIT          7
`define PCPC_VCC_HI           4
`define PCPC_VCC_LO           3
`define PCPC_VPP_HI           1
`define PCPC_VPP_LO           0

// ==========================================
// Interrupt and general-control fields
`define PCPC_RING_INDICATE_ENABLE_BIT       7
`define PCPC_RESET_BIT        6
`define PCPC_KIND_BIT         5
`define PCPC_STATUS_CHANGE_TO_HOST_IRQ_BIT     4
`define PCPC_INTSEL_HI        3
`define PCPC_INTSEL_LO        0

// ==========================================
// Interrupt select codes
`define PCPC_INTSEL_NONE      4'h0
`define PCPC_INTSEL_SMI       4'h2

`endif

// ### src/pcpc_pkg.sv
`default_nettype none

package pcpc_pkg;

	// ==========================================
	// Supply and programming voltage codes
	typedef enum logic [1:0] {
		PCPC_VCC_OFF   = 2'h0,
		PCPC_VCC_RSVD  = 2'h1,
		PCPC_VCC_5V    = 2'h2,
		PCPC_VCC_3V    = 2'h3
	} pcpc_vcc_t;

	typedef enum logic [1:0] {
		PCPC_VPP_OFF   = 2'h0,
		PCPC_VPP_VCC   = 2'h1,
		PCPC_VPP_12V   = 2'h2,
		PCPC_VPP_RSVD  = 2'h3
	} pcpc_vpp_t;

	// ==========================================
	// Power switch controls
	typedef struct packed {
		logic vcc_5v_en;
		logic vcc_3v_en;
		logic vpp_12v_en;
		logic vpp_vcc_en;
	} pcpc_pwr_t;

endpackage

`default_nettype wire

// ### src/pcpc_power_irq_ctrl.sv
`include "pcpc_defs.svh"
`default_nettype none

module pcpc_power_irq_ctrl
	import pcpc_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic        reg_mem_sel,
	input  wire logic [11:0] reg_addr,
	input  wire logic [7:0]  reg_wdata,
	output logic      [7:0]  reg_rdata,
	output logic             reg_rvalid,
	input  wire logic        battery_detect_or_ring_input,
	input  wire logic        card_func_irq,
	input  wire logic        csc_event,
	input  wire logic [3:0]  csc_route_cfg,
	output logic             card_output_gate,
	output logic             card_reset,
	output logic             card_kind_select,
	output logic             ring_indicate_enable,
	output logic             ring_indicate,
	output logic             battery_detect1,
	output pcpc_pwr_t        socket_power,
	output logic             socket_power_on_status,
	output logic             status_change_to_host_irq,
	output logic             csc_host_int,
	output logic      [15:0] csc_legacy_irq,
	output logic      [15:0] func_legacy_irq,
	output logic             func_smi
);

	// ==========================================
	// Helpers
	function automatic logic [15:0] irq_onehot(
		input logic [3:0] code
	);
		logic [15:0] v;
		v = 16'h0000;
		if (code != `PCPC_INTSEL_NONE)
		begin
			v[code] = 1'b1;
		end
		return v;
	endfunction

	function automatic logic hit(
		input logic [7:0]  idx,
		input logic [11:0] mem,
		input logic        msel,
		input logic [11:0] addr
	);
		logic idx_match;
		logic mem_match;
		idx_match = (addr == {4'h0, idx});
		mem_match = (addr == mem);
		// Bus inputs passed in so a continuous assign re-evaluates on them
		return msel ? mem_match : idx_match;
	endfunction

	// ==========================================
	// Address decode
	logic sel_power;
	logic sel_intgen;

	// Both paths reach the same flops
	assign sel_power  = hit(`PCPC_IDX_POWER, `PCPC_MEM_POWER, reg_mem_sel, reg_addr);
	assign sel_intgen = hit(`PCPC_IDX_INTGEN, `PCPC_MEM_INTGEN, reg_mem_sel, reg_addr);

	// ==========================================
	// Power-control register
	logic [7:0] power_r;

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			power_r <= `PCPC_POWER_RST;
		end
		else if (reg_wr && sel_power)
		begin
			// Reserved bits never stored, so they read back zero
			power_r <= reg_wdata & `PCPC_POWER_WMASK;
		end
	end

	// ==========================================
	// Interrupt and general-control register
	logic [7:0] intgen_r;

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			intgen_r <= `PCPC_INTGEN_RST;
		end
		else if (reg_wr && sel_intgen)
		begin
			// Every bit is storage here, nothing reserved
			intgen_r <= reg_wdata;
		end
	end

	// ==========================================
	// Register read port
	// Unmapped reads answer zero so the bus never stalls
	logic [7:0] rdata_nxt;

	always_comb
	begin
		rdata_nxt = 8'h00;
		if (sel_power)
		begin
			rdata_nxt = power_r;
		end
		else if (sel_intgen)
		begin
			rdata_nxt = intgen_r;
		end
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			reg_rdata  <= 8'h00;
			reg_rvalid <= 1'b0;
		end
		else
		begin
			reg_rdata  <= reg_rd ? rdata_nxt : 8'h00;
			reg_rvalid <= reg_rd;
		end
	end

	// ==========================================
	// Power request decode
	pcpc_vcc_t vcc_code;
	pcpc_vpp_t vpp_code;
	logic      vcc_on;
	pcpc_pwr_t pwr_nxt;

	// Reserved supply code treated as off
	assign vcc_code = pcpc_vcc_t'(power_r[`PCPC_VCC_HI:`PCPC_VCC_LO]);
	assign vpp_code = pcpc_vpp_t'(power_r[`PCPC_VPP_HI:`PCPC_VPP_LO]);
	assign vcc_on   = (vcc_code == PCPC_VCC_5V) || (vcc_code == PCPC_VCC_3V);

	always_comb
	begin
		pwr_nxt = '0;
		unique case (vcc_code)
			PCPC_VCC_OFF,
			PCPC_VCC_RSVD: pwr_nxt.vcc_5v_en = 1'b0;
			PCPC_VCC_5V:   pwr_nxt.vcc_5v_en = 1'b1;
			PCPC_VCC_3V:   pwr_nxt.vcc_3v_en = 1'b1;
		endcase
		// Program field only honoured with the supply up
		if (vcc_on)
		begin
			unique case (vpp_code)
				PCPC_VPP_OFF,
				PCPC_VPP_RSVD: pwr_nxt.vpp_vcc_en = 1'b0;
				PCPC_VPP_VCC:  pwr_nxt.vpp_vcc_en = 1'b1;
				PCPC_VPP_12V:  pwr_nxt.vpp_12v_en = 1'b1;
			endcase
		end
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			socket_power           <= '0;
			socket_power_on_status <= 1'b0;
		end
		else
		begin
			// One cycle behind the register; switch sees every write
			socket_power           <= pwr_nxt;
			socket_power_on_status <= vcc_on;
		end
	end

	// ==========================================
	// Card control outputs
	logic io_card;
	logic ring_mode;

	assign io_card   = intgen_r[`PCPC_KIND_BIT];
	assign ring_mode = intgen_r[`PCPC_RING_INDICATE_ENABLE_BIT];

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			card_output_gate     <= 1'b0;
			// Card held in reset until software sets the release bit
			card_reset           <= 1'b1;
			card_kind_select     <= 1'b0;
			ring_indicate_enable <= 1'b0;
		end
		else
		begin
			card_output_gate     <= power_r[`PCPC_COE_BIT];
			card_reset           <= ~intgen_r[`PCPC_RESET_BIT];
			card_kind_select     <= io_card;
			ring_indicate_enable <= ring_mode;
		end
	end

	// ==========================================
	// Shared battery/ring input
	// Input taken as synchronous; no extra filtering on it
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			ring_indicate   <= 1'b0;
			battery_detect1 <= 1'b0;
		end
		else
		begin
			ring_indicate   <= ring_mode && io_card && battery_detect_or_ring_input;
			battery_detect1 <= !ring_mode && !io_card && battery_detect_or_ring_input;
		end
	end

	// ==========================================
	// Interrupt steering
	logic [3:0] int_sel;
	logic       csc_to_host;

	assign int_sel     = intgen_r[`PCPC_INTSEL_HI:`PCPC_INTSEL_LO];
	// Code zero kept ORed in for older drivers
	assign csc_to_host = intgen_r[`PCPC_STATUS_CHANGE_TO_HOST_IRQ_BIT] || (int_sel == `PCPC_INTSEL_NONE);

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			status_change_to_host_irq <= 1'b0;
			csc_host_int              <= 1'b0;
			csc_legacy_irq            <= 16'h0000;
		end
		else
		begin
			status_change_to_host_irq <= csc_to_host;
			csc_host_int              <= csc_to_host && csc_event;
			// Legacy routing only while the host path is off
			csc_legacy_irq            <= csc_to_host ? 16'h0000 : (irq_onehot(csc_route_cfg) & {16{csc_event}});
		end
	end

	// ==========================================
	// Functional interrupt steering
	logic        func_active;
	logic [15:0] func_nxt;

	// Only an I/O card drives a functional interrupt
	assign func_active = io_card && card_func_irq;

	always_comb
	begin
		func_nxt = irq_onehot(int_sel) & {16{func_active}};
		// SMI is no legacy line, so bit 2 stays clear
		func_nxt[`PCPC_INTSEL_SMI] = 1'b0;
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			func_legacy_irq <= 16'h0000;
			func_smi        <= 1'b0;
		end
		else
		begin
			func_legacy_irq <= func_nxt;
			func_smi        <= func_active && (int_sel == `PCPC_INTSEL_SMI);
		end
	end

endmodule

`default_nettype wire

// ### bench/pcpc_properties.sv
`default_nettype none
module pcpc_chk
	import pcpc_pkg::*;
(
	input wire logic        clk_sys,
	input wire logic        rst,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic        reg_mem_sel,
	input wire logic [11:0] reg_addr,
	input wire logic [7:0]  reg_wdata,
	input wire logic [7:0]  reg_rdata,
	input wire logic        reg_rvalid,
	input wire logic        card_output_gate,
	input wire logic        card_reset,
	input wire logic        card_kind_select,
	input wire logic        ring_indicate,
	input wire pcpc_pwr_t   socket_power,
	input wire logic        socket_power_on_status,
	input wire logic        status_change_to_host_irq,
	input wire logic        csc_host_int,
	input wire logic        func_smi
);
	timeunit 1ns;
	timeprecision 1ps;
	// ========
	// Properties
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	rd_answer_a: assert property (reg_rd |=> reg_rvalid)
		else $error("read not answered");
	rsvd_zero_a: assert property (reg_rvalid && !$past(reg_addr[0]) |-> (reg_rdata & 8'h64) == 8'h00)
		else $error("reserved power bits set");
	gate_follow_a: assert property (reg_wr && reg_mem_sel && reg_addr == 12'h802
		|=> ##1 card_output_gate == $past(reg_wdata[7], 2)) else $error("output gate wrong");
	reset_follow_a: assert property (reg_wr && reg_mem_sel && reg_addr == 12'h803
		|=> ##1 card_reset == !$past(reg_wdata[6], 2)) else $error("card reset wrong");
	power_stat_a: assert property (socket_power_on_status == (socket_power.vcc_5v_en | socket_power.vcc_3v_en))
		else $error("power status wrong");
	vpp_gate_a: assert property (socket_power.vpp_12v_en | socket_power.vpp_vcc_en |-> socket_power_on_status)
		else $error("vpp without vcc");
	smi_io_a: assert property (func_smi |-> card_kind_select)
		else $error("smi for memory card");
	ring_io_a: assert property (ring_indicate |-> card_kind_select)
		else $error("ring for memory card");
	csc_route_a: assert property (csc_host_int |-> status_change_to_host_irq)
		else $error("status change misrouted");
	cover property (func_smi);
	cover property (csc_host_int);
	cover property (ring_indicate);
endmodule
bind pcpc_power_irq_ctrl pcpc_chk chk (.*);
`default_nettype wire

// ### bench/pcpc_card_model.sv
`default_nettype none
module pcpc_card_model
(
	input  wire logic clk_sys,
	input  wire logic card_reset,
	input  wire logic card_kind_select,
	input  wire logic want_irq,
	input  wire logic line_lvl,
	output logic      battery_detect_or_ring_input,
	output logic      card_func_irq
);
	timeunit 1ns;
	timeprecision 1ps;
	// ========
	// Card side
	assign battery_detect_or_ring_input = line_lvl;
	// Card held in reset cannot interrupt
	always_ff @(posedge clk_sys)
		card_func_irq <= want_irq & card_kind_select & !card_reset;
endmodule
`default_nettype wire

// ### bench/tb_top.sv
`default_nettype none
module tb_top
	import pcpc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// ========
	// Signals
	logic        clk_sys = '0, rst = '1, reg_wr = '0, reg_rd = '0, reg_mem_sel = '0;
	logic        want_irq = '0, line_lvl = '0, csc_event = '0;
	logic [11:0] reg_addr = '0;
	logic [7:0]  reg_wdata = '0, p = '0, c = '0, reg_rdata;
	logic [3:0]  csc_route_cfg = '0;
	logic [31:0] r;
	logic        reg_rvalid, card_output_gate, card_reset, card_kind_select, ring_indicate_enable;
	logic        ring_indicate, battery_detect1, socket_power_on_status, status_change_to_host_irq;
	logic        csc_host_int, func_smi, battery_detect_or_ring_input, card_func_irq;
	logic [15:0] csc_legacy_irq, func_legacy_irq;
	pcpc_pwr_t   socket_power;
	int          bad_count = 0, n_compared = 0, cyc = 0, seed = 22, i;
	wire logic [45:0] obs = {card_output_gate, card_reset, card_kind_select, ring_indicate_enable,
		ring_indicate, battery_detect1, socket_power, socket_power_on_status, status_change_to_host_irq,
		csc_host_int, csc_legacy_irq, func_legacy_irq, func_smi};

	pcpc_power_irq_ctrl dut (.*);
	pcpc_card_model card (.*);

	always #2.5 clk_sys = ~clk_sys;

	// ========
	// Helpers
	task conclude;
		if (bad_count == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Generous bound, run needs about 810 cycles
	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc == 6000)
		begin
			bad_count++;
			conclude;
		end
	end

	function automatic logic [45:0] expo();
		logic rt, io, on, q;
		logic [3:0] s;
		s = c[3:0];
		io = c[5];
		q = card_func_irq;
		on = p[4];
		rt = c[4] | (s == 4'h0);
		return {p[7], !c[6], io, c[7], c[7] & io & line_lvl, !c[7] & !io & line_lvl, p[4:3] == 2'h2,
			p[4:3] == 2'h3, on & (p[1:0] == 2'h2), on & (p[1:0] == 2'h1), on, rt, rt & csc_event,
			(!rt && csc_route_cfg != 4'h0 && csc_event) ? 16'h0001 << csc_route_cfg : 16'h0000,
			(io && q && s != 4'h0 && s != 4'h2) ? 16'h0001 << s : 16'h0000, (s == 4'h2) & io & q};
	endfunction

	task cmp_out(input logic [45:0] e);
		n_compared++;
		if (obs !== e)
		begin
			bad_count++;
			$display("BAD %0t %h %h", $time, obs, e);
		end
	endtask

	task cmp_rd(input logic [8:0] e);
		n_compared++;
		if ({reg_rvalid, reg_rdata} !== e)
		begin
			bad_count++;
			$display("BAD %0t %h %h", $time, {reg_rvalid, reg_rdata}, e);
		end
	endtask

	task settle;
		repeat (4) @(posedge clk_sys);
		#1;
		cmp_out(expo());
	endtask

	task wr(input logic m, input logic [11:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		#1;
		reg_wr = 1'h1;
		reg_mem_sel = m;
		reg_addr = a;
		reg_wdata = d;
		@(posedge clk_sys);
		#1;
		reg_wr = 1'h0;
		if (a[11:8] == {m, 3'h0} && a[7:0] == 8'h02)
			p = d & 8'h9B;
		if (a[11:8] == {m, 3'h0} && a[7:0] == 8'h03)
			c = d;
		settle;
	endtask

	task rd(input logic m, input logic [11:0] a);
		@(posedge clk_sys);
		#1;
		reg_rd = 1'h1;
		reg_mem_sel = m;
		reg_addr = a;
		@(posedge clk_sys);
		#1;
		reg_rd = 1'h0;
		cmp_rd({1'h1, a[11:8] != {m, 3'h0} ? 8'h00 : a[7:0] == 8'h02 ? p : a[7:0] == 8'h03 ? c : 8'h00});
	endtask

	// ========
	// Sequence
	initial
	begin
		repeat (6) @(posedge clk_sys);
		#1;
		rst = 1'h0;
		settle;
		rd(1'h0, 12'h003);
		for (i = 0; i < 16; i++)
		begin
			want_irq = 1'h1;
			csc_event = 1'h1;
			line_lvl = i[0];
			csc_route_cfg = i[3:0];
			wr(i[1], {i[1], 11'h002}, {1'h1, 2'h3, i[3:2], 1'h1, i[1:0]});
			wr(i[2], {i[2], 11'h003}, {i[0], 2'h3, i[1], i[3:0]});
			rd(i[3], {i[3], 11'h002});
		end
		for (i = 0; i < 70; i++)
		begin
			r = $random(seed);
			{line_lvl, want_irq, csc_event, csc_route_cfg} = r[30:24];
			wr(r[0] ^ (r[3] & r[4]), {r[0], 9'h000, 1'h1, r[2]}, r[15:8]);
			rd(r[16] ^ (r[5] & r[6]), {r[16], 9'h000, 1'h1, r[17]});
		end
		wr(1'h1, 12'h804, 8'hFF);
		rd(1'h1, 12'h804);
		line_lvl = 1'h0;
		csc_event = 1'h0;
		rst = 1'h1;
		@(posedge clk_sys);
		#1;
		rst = 1'h0;
		p = 8'h00;
		c = 8'h00;
		settle;
		rd(1'h1, 12'h802);
		conclude;
	end
endmodule
`default_nettype wire
